// file: hdl/ahr_top.sv
// Actuator homing sequencer, position tracking and range monitor
`timescale 1ns/10ps
module ahr_top #(
  parameter int N       = ahr_pkg::NUM_AXES,
  parameter int POS_W   = ahr_pkg::POS_W,
  parameter int SPEED_W = ahr_pkg::SPEED_W,
  parameter int STALL_W = ahr_pkg::STALL_W
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // Per-axis configuration, plus one stall_cycles limit shared by all axes
  input  wire logic [N*2-1:0]       home_mode,
  input  wire logic [N-1:0]         dir_out,
  input  wire logic [N-1:0]         free_check_en,
  input  wire logic [N-1:0]         is_stepper,
  input  wire logic [N*SPEED_W-1:0] home_speed,
  input  wire logic [N*POS_W-1:0]   range_lo,
  input  wire logic [N*POS_W-1:0]   range_hi,
  input  wire logic [N*POS_W-1:0]   stroke,
  input  wire logic [STALL_W-1:0]   stall_cycles,
  // Control
  input  wire logic                 init_req,
  input  wire logic                 run_req,
  input  wire logic                 trigger_in,
  input  wire logic [N-1:0]         follow_err,
  // Actuator feedback
  input  wire logic [N-1:0]         sig_supply_ok,
  input  wire logic [N*POS_W-1:0]   pos_delta,
  // Actuator drive
  output logic [N-1:0]              move_en,
  output logic [N-1:0]              move_dir_out,
  output logic [N*SPEED_W-1:0]      move_speed,
  // Status
  output logic [N*POS_W-1:0]        axis_pos,
  output logic [N-1:0]              homed,
  output logic                      warn_out,
  output logic                      pos_err_out,
  output logic                      init_err,
  output logic                      run_active
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (N < 1 || N > 4 || POS_W < 2 || STALL_W < 1) begin : g_bad
    $error("ahr_top: unsupported parameter values");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic       trig_s1;
  logic       trig;
  logic [N-1:0] run_s1, supply_s1;
  // Following-error pins take two stages as well
  logic [N-1:0] ferr_q;
  logic [N-1:0] supply_ok;
  logic       init_s1, init_q, runr_s1, runr_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      trig_s1   <= 1'b0;
      trig      <= 1'b0;
      supply_s1 <= '0;
      supply_ok <= '0;
      init_s1   <= 1'b0;
      init_q    <= 1'b0;
      runr_s1   <= 1'b0;
      runr_q    <= 1'b0;
      run_s1    <= '0;
      ferr_q    <= '0;
    end else begin
      trig_s1   <= trigger_in;
      trig      <= trig_s1;
      supply_s1 <= sig_supply_ok;
      supply_ok <= supply_s1;
      init_s1   <= init_req;
      init_q    <= init_s1;
      runr_s1   <= run_req;
      runr_q    <= runr_s1;
      run_s1    <= follow_err;
      ferr_q    <= run_s1;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  ahr_pkg::ahr_state_t state;
  logic [1:0]          axis;
  logic                trig_prev;
  logic [STALL_W-1:0]  still_cnt;
  logic [POS_W-1:0]    travel;
  logic                zero_now;

  logic [1:0]          cur_mode;
  logic                cur_dir;
  logic [POS_W-1:0]    cur_delta;
  logic                stalled;
  logic                cur_edge;

  always_comb begin
    cur_mode  = home_mode[axis*2 +: 2];
    cur_dir   = dir_out[axis];
    cur_delta = pos_delta[axis*POS_W +: POS_W];
    stalled   = (still_cnt >= stall_cycles) && (stall_cycles != '0);
    // Active edge is any rising edge of the synchronised trigger, whatever the travel direction
    cur_edge  = trig && !trig_prev;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state     <= ahr_pkg::AHR_IDLE;
      axis      <= 2'h0;
      trig_prev <= 1'b0;
      still_cnt <= '0;
      travel    <= '0;
      zero_now  <= 1'b0;
      init_err  <= 1'b0;
    end else begin
      trig_prev <= trig;
      zero_now  <= 1'b0;
      case (state)
        ahr_pkg::AHR_IDLE: begin
          if (init_q) begin
            axis  <= 2'h0;
            state <= ahr_pkg::AHR_START;
          end
        end
        ahr_pkg::AHR_START: begin
          still_cnt <= '0;
          travel    <= '0;
          case (cur_mode)
            ahr_pkg::MODE_STOP: begin
              state <= ahr_pkg::AHR_SEEK;
            end
            ahr_pkg::MODE_TRIGGER: begin
              state <= trig ? ahr_pkg::AHR_BACKOFF : ahr_pkg::AHR_SEEK;
            end
            ahr_pkg::MODE_ACTUAL: begin
              zero_now <= 1'b1;
              state    <= free_check_en[axis] ? ahr_pkg::AHR_FREE : ahr_pkg::AHR_NEXT;
            end
            default: begin
              state <= ahr_pkg::AHR_NEXT;
            end
          endcase
        end
        ahr_pkg::AHR_BACKOFF: begin
          if (!trig) begin
            state <= ahr_pkg::AHR_SEEK;
          end
        end
        ahr_pkg::AHR_SEEK: begin
          still_cnt <= (cur_delta == '0) ? still_cnt + 1'b1 : '0;
          if ((cur_mode == ahr_pkg::MODE_STOP && stalled) ||
              (cur_mode == ahr_pkg::MODE_TRIGGER && cur_edge)) begin
            zero_now  <= 1'b1;
            still_cnt <= '0;
            state     <= free_check_en[axis] ? ahr_pkg::AHR_FREE : ahr_pkg::AHR_NEXT;
          end
        end
        ahr_pkg::AHR_FREE: begin
          still_cnt <= (cur_delta == '0) ? still_cnt + 1'b1 : '0;
          travel    <= travel + (cur_delta[POS_W-1] ? -cur_delta : cur_delta);
          if (stalled) begin
            init_err <= 1'b1;
            state    <= ahr_pkg::AHR_FAIL;
          end else if (travel >= stroke[axis*POS_W +: POS_W]) begin
            state <= ahr_pkg::AHR_NEXT;
          end
        end
        ahr_pkg::AHR_NEXT: begin
          if (axis == 2'(N-1)) begin
            state <= ahr_pkg::AHR_DONE;
          end else begin
            axis  <= axis + 2'h1;
            state <= ahr_pkg::AHR_START;
          end
        end
        ahr_pkg::AHR_DONE: begin
          state <= ahr_pkg::AHR_DONE;
        end
        ahr_pkg::AHR_FAIL: begin
          state <= ahr_pkg::AHR_FAIL;
        end
        default: begin
          state <= ahr_pkg::AHR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Motion command
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      move_en      <= '0;
      move_dir_out <= '0;
      move_speed   <= '0;
    end else begin
      move_en      <= '0;
      move_dir_out <= '0;
      move_speed   <= '0;
      if (state == ahr_pkg::AHR_SEEK || state == ahr_pkg::AHR_BACKOFF ||
          state == ahr_pkg::AHR_FREE) begin
        move_en[axis]                        <= 1'b1;
        move_speed[axis*SPEED_W +: SPEED_W]  <= home_speed[axis*SPEED_W +: SPEED_W];
        // Back off runs opposite; free check runs away from the zero
        move_dir_out[axis] <= (state == ahr_pkg::AHR_SEEK) ? cur_dir : !cur_dir;
      end
    end
  end

  // ----------------------------------------
  // Position tracking and homed flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      axis_pos <= '0;
      homed    <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (zero_now && axis == 2'(i)) begin
          axis_pos[i*POS_W +: POS_W] <= ahr_pkg::POS_RST;
          homed[i]                   <= 1'b1;
        end else if (!supply_ok[i]) begin
          // Lost signal supply forgets the zero
          homed[i] <= 1'b0;
        end else if (!is_stepper[i] || move_en[i]) begin
          // Steppers have no pick-up, so only driven motion is counted
          axis_pos[i*POS_W +: POS_W] <= axis_pos[i*POS_W +: POS_W]
                                        + pos_delta[i*POS_W +: POS_W];
        end
      end
    end
  end

  // ----------------------------------------
  // Range monitor
  // ----------------------------------------
  logic [N-1:0] outside;

  for (genvar g = 0; g < N; g++) begin : g_rng
    ahr_range_check #(
      .POS_W (POS_W)
    ) u_rng (
      .clk     (clk),
      .srst    (srst),
      .pos     (axis_pos[g*POS_W +: POS_W]),
      .lo      (range_lo[g*POS_W +: POS_W]),
      .hi      (range_hi[g*POS_W +: POS_W]),
      .enable  (homed[g]),
      .outside (outside[g])
    );
  end

  // ----------------------------------------
  // Collective outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      warn_out    <= 1'b1;
      pos_err_out <= 1'b0;
      run_active  <= 1'b0;
    end else begin
      warn_out    <= (homed != {N{1'b1}});
      // Range flags and synchronised following errors share one output
      pos_err_out <= (|outside) || (|ferr_q);
      run_active  <= runr_q && !warn_out && !init_err;
    end
  end

endmodule

// file: hdl/ahr_pkg.sv
// Package: constants and types for the actuator homing and range monitor
package ahr_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_AXES   = 4;
  localparam int POS_W      = 24;
  localparam int SPEED_W    = 8;
  localparam int STALL_W    = 8;

  // ----------------------------------------
  // Homing modes
  // ----------------------------------------
  localparam logic [1:0] MODE_STOP    = 2'h0;
  localparam logic [1:0] MODE_TRIGGER = 2'h1;
  localparam logic [1:0] MODE_ACTUAL  = 2'h2;
  localparam logic [1:0] MODE_NONE    = 2'h3;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [POS_W-1:0] POS_RST       = 24'h000000;
  localparam int               STALL_CYC_DEF = 16;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    AHR_IDLE    = 3'b000,
    AHR_START   = 3'b001,
    AHR_BACKOFF = 3'b010,
    AHR_SEEK    = 3'b011,
    AHR_FREE    = 3'b100,
    AHR_NEXT    = 3'b101,
    AHR_DONE    = 3'b110,
    AHR_FAIL    = 3'b111
  } ahr_state_t;

endpackage

// file: hdl/ahr_range_check.sv
// Per-axis position range compare with registered flag
`timescale 1ns/10ps
module ahr_range_check #(
  parameter int POS_W = 24
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Range and position
  input  wire logic [POS_W-1:0] pos,
  input  wire logic [POS_W-1:0] lo,
  input  wire logic [POS_W-1:0] hi,
  input  wire logic             enable,
  // Result
  output logic                  outside
);

  // ----------------------------------------
  // Compare
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      outside <= 1'b0;
    end else begin
      outside <= enable && (($signed(pos) < $signed(lo)) || ($signed(pos) > $signed(hi)));
    end
  end

endmodule

// file: dv/ahr_act_model.sv
// Actuator model: axis positions with hard stops and a relayed sensor
`timescale 1ns/10ps
module ahr_act_model #(
  parameter int N     = 4,
  parameter int POS_W = 24,
  parameter int LIM   = 20,
  parameter int TRIG  = 8
) (
  // Clock
  input  wire logic             clk,
  // Drive and bench controls
  input  wire logic [N-1:0]     move_en,
  input  wire logic [N-1:0]     move_dir_out,
  input  wire logic [N-1:0]     push,
  input  wire logic [N-1:0]     tsel,
  // Feedback
  output logic [N*POS_W-1:0]    pos_delta,
  output logic                  trigger_in
);
  int p [N] = '{default: 0};
  int d [N];
  always_comb begin
    trigger_in = 1'b0;
    for (int i = 0; i < N; i++) begin
      d[i] = push[i] ? 1 : !move_en[i] ? 0 : move_dir_out[i] ? 1 : -1;
      if (p[i] + d[i] > LIM || p[i] + d[i] < -LIM) d[i] = 0;
      pos_delta[i*POS_W +: POS_W] = POS_W'(d[i]);
      trigger_in = trigger_in | (tsel[i] && p[i] >= TRIG);
    end
  end
  always_ff @(posedge clk) for (int i = 0; i < N; i++) p[i] <= p[i] + d[i];
endmodule

// file: dv/ahr_top_asserts.sv
// Checker: port assertions of the homing and range monitor
`timescale 1ns/10ps
module ahr_top_asserts #(
  parameter int N       = 4,
  parameter int POS_W   = 24,
  parameter int SPEED_W = 8
) (
  input wire logic                 clk,
  input wire logic                 srst,
  input wire logic [N-1:0]         free_check_en,
  input wire logic [N*SPEED_W-1:0] home_speed,
  input wire logic [N-1:0]         follow_err,
  input wire logic [N-1:0]         move_en,
  input wire logic [N*SPEED_W-1:0] move_speed,
  input wire logic [N*POS_W-1:0]   axis_pos,
  input wire logic [N-1:0]         homed,
  input wire logic                 warn_out,
  input wire logic                 pos_err_out,
  input wire logic                 init_err,
  input wire logic                 run_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_warn_hi; (homed != '1) |=> warn_out; endproperty
  a_warn_hi: assert property (p_warn_hi) else $error("warning low");
  property p_warn_fall; $fell(warn_out) |-> &$past(homed); endproperty
  a_warn_fall: assert property (p_warn_fall) else $error("early warn drop");
  property p_run_block;
    (warn_out && $past(warn_out)) || (init_err && $past(init_err)) |-> !run_active;
  endproperty
  a_run_block: assert property (p_run_block) else $error("run not blocked");
  property p_one; $onehot0(move_en); endproperty
  a_one: assert property (p_one) else $error("two axes moving");
  property p_order; (homed & ~((move_en << 1) - 1'b1)) == '0; endproperty
  a_order: assert property (p_order) else $error("axis out of order");
  property p_init_err; $rose(init_err) |-> (free_check_en & $past(move_en)) != '0; endproperty
  a_init_err: assert property (p_init_err) else $error("stray init error");
  property p_collect; (follow_err != '0) [*4] |-> pos_err_out; endproperty
  a_collect: assert property (p_collect) else $error("no collective error");
  for (genvar i = 0; i < N; i++) begin : g_ax
    property p_speed;
      move_speed[i*SPEED_W +: SPEED_W] ==
        (move_en[i] ? home_speed[i*SPEED_W +: SPEED_W] : '0);
    endproperty
    a_speed: assert property (p_speed) else $error("wrong speed");
    property p_zero; $rose(homed[i]) |-> axis_pos[i*POS_W +: POS_W] == '0; endproperty
    a_zero: assert property (p_zero) else $error("homed without zero");
  end
  c_done: cover property (homed == '1);
  c_err: cover property ($rose(init_err));
  c_pos: cover property ($rose(pos_err_out));
endmodule
bind ahr_top ahr_top_asserts #(.N(N), .POS_W(POS_W), .SPEED_W(SPEED_W)) u_chk (
  .clk, .srst, .free_check_en, .home_speed, .follow_err, .move_en, .move_speed,
  .axis_pos, .homed, .warn_out, .pos_err_out, .init_err, .run_active);

// file: dv/ahr_top_tb.sv
// Testbench: homing runs, tracking, range and error scenarios
`timescale 1ns/10ps
module ahr_top_tb;
  localparam int N = ahr_pkg::NUM_AXES;
  localparam int W = ahr_pkg::POS_W;
  logic           clk = 1'b0, srst = 1'b1, init_req = 1'b0, run_req = 1'b0;
  logic [2*N-1:0] home_mode = '0;
  logic [N-1:0]   dir_out = '0, free_check_en = '0, is_stepper = 4'h4, follow_err = '0;
  logic [N-1:0]   sig_supply_ok = '1, push = '0, tsel = 4'h2;
  logic [8*N-1:0] home_speed = 32'h44332211;
  logic [N*W-1:0] range_lo = {N{24'hffff9c}}, range_hi = {N{24'h000064}};
  logic [N*W-1:0] stroke = {N{24'h000064}};
  logic [7:0]     stall_cycles = 8'h04;
  logic           trigger_in, warn_out, pos_err_out, init_err, run_active, saw_back = 1'b0;
  logic [N*W-1:0] pos_delta, axis_pos;
  logic [N-1:0]   move_en, move_dir_out, homed;
  logic [8*N-1:0] move_speed;
  int             errors = 0, check_count = 0, cyc = 0;

  ahr_top uut (.clk, .srst, .home_mode, .dir_out, .free_check_en, .is_stepper,
    .home_speed, .range_lo, .range_hi, .stroke, .stall_cycles, .init_req, .run_req,
    .trigger_in, .follow_err, .sig_supply_ok, .pos_delta, .move_en, .move_dir_out,
    .move_speed, .axis_pos, .homed, .warn_out, .pos_err_out, .init_err, .run_active);
  ahr_act_model prt (.clk, .move_en, .move_dir_out, .push, .tsel, .pos_delta,
    .trigger_in);

  initial forever #50 clk = ~clk;
  task automatic chk(input logic [N*W-1:0] seen, input logic [N*W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_for(input logic [N-1:0] m);
    for (int i = 0; i < 800 && (homed & m) !== m && init_err !== 1'b1; i++) @(negedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (move_en[1] && !move_dir_out[1]) saw_back <= 1'b1;
    if (cyc == 6000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    tick(6);
    srst <= 1'b0;
    @(negedge clk);
    chk(warn_out, 1);
    @(posedge clk);
    {run_req, init_req, home_mode, dir_out} <= {2'b11, 8'h24, 4'h3};
    tick(6);
    @(negedge clk);
    chk(run_active, 0);
    chk(move_en, 1);
    chk(move_speed, 32'h11);
    wait_for(4'hf);
    chk(homed, 4'hf);
    chk(axis_pos[W-1:0], 0);
    chk(axis_pos[3*W-1:2*W], 0);
    chk(prt.p[0], 20);
    chk(prt.p[3], -20);
    chk(prt.p[2], 0);
    chk(prt.p[1] >= 8 && prt.p[1] <= 12, 1);
    tick(3);
    @(negedge clk);
    chk(warn_out, 0);
    chk(run_active, 1);
    @(posedge clk) push <= 4'hc;
    tick(5);
    push <= '0;
    tick(2);
    @(negedge clk);
    chk(axis_pos[4*W-1:3*W], 5);
    chk(axis_pos[3*W-1:2*W], 0);
    @(posedge clk) range_hi[4*W-1:3*W] <= 24'h000004;
    tick(3);
    @(negedge clk);
    chk(pos_err_out, 1);
    @(posedge clk) range_hi[4*W-1:3*W] <= 24'h000064;
    tick(3);
    @(negedge clk);
    chk(pos_err_out, 0);
    @(posedge clk) follow_err <= 4'h4;
    tick(5);
    @(negedge clk);
    chk(pos_err_out, 1);
    @(posedge clk) {follow_err, sig_supply_ok} <= 8'h0d;
    tick(5);
    @(negedge clk);
    chk(homed, 4'hd);
    chk(warn_out, 1);
    @(posedge clk);
    {srst, init_req, sig_supply_ok, home_mode} <= {2'b10, 4'hf, 8'hc6};
    {dir_out, free_check_en} <= 8'h24;
    tick(6);
    srst <= 1'b0;
    @(negedge clk);
    chk(homed, 0);
    @(posedge clk) init_req <= 1'b1;
    wait_for(4'hf);
    chk(init_err, 1);
    chk(saw_back, 1);
    chk(prt.p[2], 20);
    chk(warn_out, 1);
    chk(run_active, 0);
    report_and_stop();
  end
endmodule
